/* verilog/mbst_pkg.sv */
// Shared constants for the memory board bus-slave timing block
package mbst_pkg;
    // Clock period and documented times, in ns
    localparam int CLK_PERIOD_NS   = 50;
    localparam int CMD_DELAY_NS    = 60;
    localparam int CMD_DELAY_CYC   =
        (CMD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Terminal-count field and default (suits 200 ns memories)
    localparam int CNT_W           = 4;
    localparam logic [3:0] CNT_DEFAULT = 4'h7;
    localparam int DLY_W           = 2;
    // Strobe-to-valid arithmetic offsets, in ns
    localparam logic [11:0] ADV_BASE_NS = 12'h069;
    localparam logic [11:0] ADV_GAP_NS  = 12'h09C;
    // Transfer types
    typedef enum logic [1:0] {
        MBST_XFER_NONE, MBST_XFER_LOW, MBST_XFER_HIGH, MBST_XFER_WORD
    } mbst_xfer_t;
    // Access sequence states
    typedef enum logic [1:0] {
        MBST_IDLE, MBST_DELAY, MBST_COUNT, MBST_ACK
    } mbst_state_t;
endpackage

/* verilog/mbst_ctrl.sv */
// Bus-slave control: interface select, acknowledge timing, byte lanes
`timescale 1ns/1ps
module mbst_ctrl #(
    parameter int CNT_W = mbst_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Configuration
    input  wire logic              local_mode_in,
    input  wire logic              optimized_in,
    input  wire logic              wide_mode_in,
    input  wire logic [CNT_W-1:0]  term_count_in,
    input  wire logic              use_default_cnt_in,
    // Host command
    input  wire logic              cmd_in,
    input  wire logic              write_in,
    input  wire logic              data_strobe_low_in,
    input  wire logic              upper_byte_enable_in,
    input  wire logic              low_address_bit_in,
    // Memory read data
    input  wire logic [15:0]       mem_rdata_in,
    input  wire logic              mem_rdata_valid_in,
    // Memory timing inputs; buffer and receiver enables
    input  wire logic [11:0]       t_ce_in,
    input  wire logic [11:0]       t_oe_in,
    input  wire logic [11:0]       t_ad_in,
    output logic                   sys_addr_buf_en_out,
    output logic                   sys_cmd_rcv_en_out,
    output logic                   local_addr_buf_en_out,
    // Handshake and strobes
    output logic                   card_selected_flag_out,
    output logic                   system_bus_reply_done_out,
    output logic                   local_bus_reply_done_out,
    output logic                   write_strobe_low_out,
    output logic                   mem_cycle_start_out,
    // Byte lanes, read data and strobe-to-valid time
    output logic                   upper_lane_select_out,
    output logic                   low_lane_select_out,
    output logic [1:0]             xfer_type_out,
    output logic [15:0]            host_rdata_out,
    output logic [11:0]            strobe_to_valid_time_out
);
    localparam int DW = mbst_pkg::DLY_W;

    mbst_pkg::mbst_state_t state_reg, state_next;
    logic [DW-1:0]    dly_reg, dly_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             ack_reg, ack_next;
    logic             sel_reg, sel_next;
    logic             we_reg, we_next;
    logic             mode_reg, mode_next;
    logic             data_strobe_low_d_reg, data_strobe_low_d_next;
    logic [15:0]      rdata_reg, rdata_next;
    logic [1:0]       xfer_reg, xfer_next;
    logic [11:0]      adv_reg, adv_next;
    logic [CNT_W-1:0] term;
    logic             start_ok;
    logic             data_strobe_low_rise;
    logic [11:0]      adv_long;
    logic [11:0]      adv_short;

    // transfer type decode
    // Decode transfer type from enable and bit zero
    function automatic logic [1:0] xfer_decode(input logic ube,
                                                input logic a0);
        if (ube && a0)
            xfer_decode = mbst_pkg::MBST_XFER_HIGH;
        else if (!ube && !a0)
            xfer_decode = mbst_pkg::MBST_XFER_LOW;
        else if (ube && !a0)
            xfer_decode = mbst_pkg::MBST_XFER_WORD;
        else
            xfer_decode = mbst_pkg::MBST_XFER_NONE;
    endfunction

    assign term = use_default_cnt_in ? CNT_W'(mbst_pkg::CNT_DEFAULT)
                                     : term_count_in;
    // normal local mode waits for data strobe
    assign start_ok = !mode_reg || optimized_in || !data_strobe_low_in;
    assign data_strobe_low_rise = data_strobe_low_in && !data_strobe_low_d_reg;
    // both terms of the worst-case sum
    // Sums wrap above 4095 ns; real memory times sit far below
    assign adv_long  = t_ad_in + mbst_pkg::ADV_GAP_NS + t_oe_in;
    assign adv_short = mbst_pkg::ADV_BASE_NS + t_ce_in;

    always_comb begin
        state_next  = state_reg;
        dly_next    = dly_reg;
        cnt_next    = cnt_reg;
        ack_next    = ack_reg;
        sel_next    = sel_reg;
        we_next     = we_reg;
        mode_next   = local_mode_in;
        data_strobe_low_d_next = data_strobe_low_in;
        rdata_next  = rdata_reg;
        xfer_next   = xfer_decode(upper_byte_enable_in, low_address_bit_in);
        if (adv_long > adv_short)
            adv_next = adv_long;
        else
            adv_next = adv_short;
        case (state_reg)
            mbst_pkg::MBST_IDLE: begin
                if (cmd_in && start_ok) begin
                    state_next = mbst_pkg::MBST_DELAY;
                    dly_next   = '0;
                end
            end
            mbst_pkg::MBST_DELAY: begin
                if (dly_reg == DW'(mbst_pkg::CMD_DELAY_CYC - 1)) begin
                    sel_next   = 1'b1;
                    cnt_next   = '0;
                    we_next    = write_in;
                    state_next = mbst_pkg::MBST_COUNT;
                end else begin
                    dly_next = dly_reg + 1'b1;
                end
            end
            mbst_pkg::MBST_COUNT: begin
                // ack on the edge after terminal count
                if (cnt_reg == term) begin
                    ack_next   = 1'b1;
                    state_next = mbst_pkg::MBST_ACK;
                    // system mode ends write on ack
                    if (!mode_reg)
                        we_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
                // capture read data for the reply
                if (mem_rdata_valid_in)
                    rdata_next = mem_rdata_in;
            end
            mbst_pkg::MBST_ACK: begin
                if (mem_rdata_valid_in)
                    rdata_next = mem_rdata_in;
            end
            default: state_next = mbst_pkg::MBST_IDLE;
        endcase
        // local mode ends write on data strobe rise
        if (mode_reg && data_strobe_low_rise)
            we_next = 1'b0;
        if (!cmd_in && state_reg != mbst_pkg::MBST_IDLE) begin
            state_next = mbst_pkg::MBST_IDLE;
            sel_next   = 1'b0;
            cnt_next   = '0;
            ack_next   = 1'b0;
            we_next    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg  <= mbst_pkg::MBST_IDLE;
            dly_reg    <= '0;
            cnt_reg    <= '0;
            ack_reg    <= 1'b0;
            sel_reg    <= 1'b0;
            we_reg     <= 1'b0;
            mode_reg   <= 1'b0;
            data_strobe_low_d_reg <= 1'b1;
            rdata_reg  <= 16'h0000;
            xfer_reg   <= mbst_pkg::MBST_XFER_NONE;
            adv_reg    <= 12'h000;
        end else begin
            state_reg  <= state_next;
            dly_reg    <= dly_next;
            cnt_reg    <= cnt_next;
            ack_reg    <= ack_next;
            sel_reg    <= sel_next;
            we_reg     <= we_next;
            mode_reg   <= mode_next;
            data_strobe_low_d_reg <= data_strobe_low_d_next;
            rdata_reg  <= rdata_next;
            xfer_reg   <= xfer_next;
            adv_reg    <= adv_next;
        end
    end

    // one address buffer set at a time
    assign sys_addr_buf_en_out   = !mode_reg;
    assign local_addr_buf_en_out = mode_reg;
    assign sys_cmd_rcv_en_out    = !mode_reg;
    assign system_bus_reply_done_out = ack_reg && !mode_reg;
    // local reply may lead valid data
    assign local_bus_reply_done_out  = ack_reg && mode_reg;
    assign card_selected_flag_out    = sel_reg;
    assign write_strobe_low_out      = !we_reg;
    assign mem_cycle_start_out       = sel_reg;
    // odd devices gated by upper enable
    assign upper_lane_select_out = wide_mode_in ? upper_byte_enable_in
                                                : 1'b1;
    // even devices gated by address bit
    assign low_lane_select_out   = wide_mode_in ? !low_address_bit_in
                                                : 1'b1;
    assign xfer_type_out = xfer_reg;
    // high byte swapped onto low lane in system mode
    assign host_rdata_out = (!mode_reg &&
                             xfer_reg == mbst_pkg::MBST_XFER_HIGH) ?
                            {8'h00, rdata_reg[15:8]} : rdata_reg;
    assign strobe_to_valid_time_out = adv_reg;

    // Access start: command taken in idle
    sequence acc_take_s;
        state_reg == mbst_pkg::MBST_IDLE && cmd_in && start_ok;
    endsequence
    // Command still held across the decode delay
    sequence cmd_held_s;
        cmd_in [*2];
    endsequence

    ack_after_cnt_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        state_reg == mbst_pkg::MBST_COUNT && cnt_reg == term && cmd_in
        |=> ack_reg) else $error("ack missing after count");
    sel_after_dly_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(sel_reg) |-> $past(state_reg) == mbst_pkg::MBST_DELAY)
        else $error("flag set without delay");
    one_buffer_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        sys_addr_buf_en_out != local_addr_buf_en_out)
        else $error("buffer enables clash");
    cmd_clear_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !cmd_in |=> !ack_reg && !sel_reg)
        else $error("access not cleared");
    decode_delay_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(cmd_in) && state_reg == mbst_pkg::MBST_IDLE |=> !sel_reg)
        else $error("select too early");
    // select right after the delay; repeat count is the 2-cycle delay
    sel_on_time_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        acc_take_s ##1 cmd_held_s |=> sel_reg)
        else $error("select not on time");
    // write ends with ack in system mode
    we_end_ack_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        ack_reg && !mode_reg |-> write_strobe_low_out)
        else $error("write strobe past ack");
    // write strobe starts with the flag
    we_start_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(sel_reg) && $past(write_in && !mode_reg)
        |-> !write_strobe_low_out) else $error("write strobe not started");
    // local write ends on strobe rise
    local_we_end_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        mode_reg && data_strobe_low_rise |=> write_strobe_low_out)
        else $error("local write strobe not ended");
    ack_needs_sel_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        ack_reg |-> sel_reg) else $error("ack without select");
    // data captured by the system reply
    sys_data_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(system_bus_reply_done_out) && $past(mem_rdata_valid_in)
        |-> rdata_reg == $past(mem_rdata_in))
        else $error("reply before data");
    // normal local mode waits for the strobe
    strobe_wait_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        state_reg == mbst_pkg::MBST_IDLE && mode_reg && !optimized_in &&
        data_strobe_low_in |=> state_reg == mbst_pkg::MBST_IDLE)
        else $error("cycle started before strobe");
    // system mode on the first edge after reset
    reset_mode_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $past(rst_in) |-> sys_addr_buf_en_out && sys_cmd_rcv_en_out)
        else $error("not in system mode after reset");
    rcv_mode_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        !$past(rst_in) |-> sys_cmd_rcv_en_out != $past(local_mode_in))
        else $error("receiver mismatch");
endmodule

/* bench/mbst_master_model.sv */
// Bus master model: holds each command until the reply
`timescale 1ns/1ps
module mbst_master_model (
    input  wire logic clk_in,
    input  wire logic go_in,
    input  wire logic wr_in,
    input  wire logic late_in,
    input  wire logic reply_in,
    output logic      cmd_out,
    output logic      write_out,
    output logic      data_strobe_low_low_out,
    output int        cycles_out
);
    int   lag;
    logic held;
    initial begin
        cmd_out = 1'b0;
        write_out = 1'b0;
        data_strobe_low_low_out = 1'b1;
        lag = 0;
        forever begin
            @(negedge clk_in);
            if (cmd_out && reply_in === 1'b1) begin
                cmd_out = 1'b0;
                write_out = ~write_out;
                data_strobe_low_low_out = 1'b1;
            end else if (go_in && !cmd_out) begin
                cmd_out = 1'b1;
                write_out = wr_in;
                data_strobe_low_low_out = late_in;
                lag = 3;
            end else if (cmd_out && data_strobe_low_low_out) begin
                // Slow master: strobe may trail the command
                lag--;
                if (lag == 0) data_strobe_low_low_out = 1'b0;
            end
        end
    end
    // Edges with the command up, take and reply edges included
    initial begin
        cycles_out = 0;
        held = 1'b0;
        forever begin
            @(posedge clk_in);
            if (cmd_out)
                cycles_out = held ? cycles_out + 1 : 1;
            held = cmd_out;
        end
    end
endmodule

/* bench/tb_memory_board_bus_slave_timing.sv */
// Self-checking bench for the bus-slave timing block
`timescale 1ns/1ps
module tb_memory_board_bus_slave_timing;
    logic        ref_clk_in, rst_in, lmode, opt, wide, use_def;
    logic        go, wr, late, ube, lab, mval, sys_buf, sys_rcv;
    logic        loc_buf, flag, sys_ack, loc_ack, wstb_low, up_sel;
    logic        lo_sel, cmd, write_lv, data_strobe_low_low, mcs;
    logic [3:0]  term;
    logic [15:0] mdata, hdata;
    logic [11:0] tce, toe, tad, strobe_to_valid_time;
    logic [1:0]  xtype;
    int          cycles, seed, mismatches, n_compared, i;

    mbst_ctrl mbst_ctrl_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .local_mode_in(lmode), .optimized_in(opt), .wide_mode_in(wide),
        .term_count_in(term), .use_default_cnt_in(use_def),
        .cmd_in(cmd), .write_in(write_lv), .data_strobe_low_in(data_strobe_low_low),
        .upper_byte_enable_in(ube), .low_address_bit_in(lab),
        .mem_rdata_in(mdata), .mem_rdata_valid_in(mval),
        .t_ce_in(tce), .t_oe_in(toe), .t_ad_in(tad),
        .sys_addr_buf_en_out(sys_buf), .sys_cmd_rcv_en_out(sys_rcv),
        .local_addr_buf_en_out(loc_buf), .card_selected_flag_out(flag),
        .system_bus_reply_done_out(sys_ack),
        .local_bus_reply_done_out(loc_ack), .write_strobe_low_out(wstb_low),
        .mem_cycle_start_out(mcs), .upper_lane_select_out(up_sel),
        .low_lane_select_out(lo_sel), .xfer_type_out(xtype),
        .host_rdata_out(hdata), .strobe_to_valid_time_out(strobe_to_valid_time));

    mbst_master_model mbst_master_model_i (.clk_in(ref_clk_in),
        .go_in(go), .wr_in(wr), .late_in(late),
        .reply_in(lmode ? loc_ack : sys_ack), .cmd_out(cmd),
        .write_out(write_lv), .data_strobe_low_low_out(data_strobe_low_low), .cycles_out(cycles));

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [11:0] adv_time();
        logic [11:0] a;
        logic [11:0] b;
        a = mbst_pkg::ADV_BASE_NS + tce;
        b = tad + mbst_pkg::ADV_GAP_NS + toe;
        return (b > a) ? b : a;
    endfunction

    task automatic access(input logic lm, input logic op, input logic lt);
        int   n;
        int   exp_n;
        logic rep;
        @(negedge ref_clk_in);
        {use_def, wr, ube, lab, term} = 8'($random(seed));
        {wide, mdata} = 17'($random(seed));
        tce = 12'($random(seed)) & 12'h03ff;
        toe = 12'($random(seed)) & 12'h03ff;
        tad = 12'($random(seed)) & 12'h03ff;
        lmode = lm;
        opt = op;
        late = lt;
        repeat (2) @(negedge ref_clk_in);
        check(16'(sys_buf), 16'(!lm), "system buffers");
        check(16'(loc_buf), 16'(lm), "local buffers");
        check(16'(sys_rcv), 16'(!lm), "command receiver");
        // Edges with the command up: take, delay, count, reply
        exp_n = (use_def ? int'(mbst_pkg::CNT_DEFAULT) : int'(term))
                + mbst_pkg::CMD_DELAY_CYC + 2
                + ((lm && !op && lt) ? 3 : 0);
        go <= 1'b1;
        n = 0;
        rep = 1'b0;
        while (!rep && n < 80) begin
            @(negedge ref_clk_in);
            rep = ((lm ? loc_ack : sys_ack) === 1'b1);
            n++;
        end
        check(16'(cycles), 16'(exp_n), "reply latency");
        check(16'(lm ? sys_ack : loc_ack), 16'h0000, "other reply");
        check(16'(flag), 16'h0001, "selected flag");
        check(16'(mcs), 16'h0001, "cycle started");
        if (wr) check(16'(wstb_low), 16'(!lm), "write strobe");
        if (!wr && (ube || !lab))
            check(hdata, (!lm && ube && lab) ? {8'h00, mdata[15:8]} : mdata,
                  "read data");
        if (!wr && lm) check(hdata, mdata, "local data at sample");
        check(16'(xtype), 16'({ube, ~lab}), "transfer type");
        check(16'(strobe_to_valid_time), 16'(adv_time()), "strobe to valid");
        if (wide) check(16'(up_sel), 16'(ube), "upper lane");
        else check(16'(up_sel), 16'h0001, "upper 8-bit");
        if (wide) check(16'(lo_sel), 16'(!lab), "lower lane");
        else check(16'(lo_sel), 16'h0001, "lower 8-bit");
        go <= 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(16'(flag), 16'h0000, "flag cleared");
        check(16'(mcs), 16'h0000, "cycle ended");
        check(16'(lm ? loc_ack : sys_ack), 16'h0000, "reply cleared");
        check(16'(wstb_low), 16'h0001, "strobe ended");
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        seed = 85;
        mismatches = 0;
        n_compared = 0;
        rst_in = 1'b1;
        {lmode, opt, wide, use_def, go, wr, late, ube, lab} = '0;
        mval = 1'b1;
        term = 4'h0;
        mdata = 16'h0000;
        {tce, toe, tad} = '0;
        repeat (12) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        check(16'(sys_buf), 16'h0001, "reset mode");
        check(16'(loc_buf), 16'h0000, "reset local");
        for (i = 0; i < 32; i++) access(i[0], i[1], i[2]);
        // Mid-run reset while the local mode is requested
        @(negedge ref_clk_in);
        lmode = 1'b1;
        repeat (2) @(negedge ref_clk_in);
        check(16'(loc_buf), 16'h0001, "local before reset");
        rst_in = 1'b1;
        @(negedge ref_clk_in);
        check(16'(sys_buf), 16'h0001, "mode in reset");
        lmode = 1'b0;
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        check(16'(sys_buf), 16'h0001, "mode after reset");
        conclude();
    end

    // Generous bound: an access takes under forty cycles
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        mismatches++;
        conclude();
    end
endmodule
